/* i2cs_regs.svh */
// Purpose: Constants for the two-wire control slave
// Assumes: Included by the package and the control slave module
// Notes:   Widths and codes only, no logic
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH

`define I2CS_DEV_ADDR   7'h1B
`define I2CS_MULTI_BASE 8'h20
`define I2CS_GROUP_SZ   5'h04
`define I2CS_BUF_BYTES  20
`define I2CS_BUF_W      160
`define I2CS_BYTE_BITS  4'h8
`define I2CS_CNT_W      5

`endif

/* i2cs_pkg.sv */
// Purpose: Types for the two-wire control slave
// Assumes: Constants come from the register header
// Notes:   All state of the slave lives in one packed struct
`include "i2cs_regs.svh"

package i2cs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_TXACK,
    ST_IGNORE
  } i2cs_state_type;

  typedef struct packed {
    i2cs_state_type               st;
    logic                         scl_q;
    logic                         sda_q;
    logic [3:0]                   bitcnt;
    logic [7:0]                   shreg;
    logic                         rw;
    logic                         sub_phase;
    logic [7:0]                   sub_addr;
    logic [`I2CS_CNT_W-1:0]       cnt;
    logic [`I2CS_BUF_W-1:0]       dbuf;
    logic                         wr_valid;
    logic [7:0]                   wr_addr;
    logic                         sda_oe;
    logic                         sda_out;
  } i2cs_regs_type;

endpackage

/* i2cs_slave.sv */
// Purpose: Slave-only two-wire control port of the audio_processing_core
// Assumes: scl_in and sda_in are synchronous to sys_clk, far slower than it
// Notes:   Never stretches the clock; every step follows the master's edges
`timescale 1ns/1ps
`include "i2cs_regs.svh"

// Overview of operation
// - Works as slave at 100 kHz and 400 kHz, single and multi-byte.
// - Slave only: never arbitrates, initiates or stretches the clock.
// - All bytes are eight bits, most significant bit first.
// - Receiver acknowledges each byte in the next clock period.
// - Start and stop conditions are detected while SCL is high.
// - Data on SDA changes only while SCL is low.
// - SDA is only pulled low or released, open drain.
// - Address byte is 7-bit 0011011 plus direction bit.
// - On address match SDA is held low for the acknowledge period.
// - Any number of bytes is accepted between start and stop.
// - Subaddresses 0x20 and up use whole groups of 4 bytes.
// - Reads stream bytes from the subaddress while the master acknowledges.
// - Unused bits of narrow registers read as zero.
// - Incomplete write data is dropped on stop or repeated start.
// - Sequential writes advance the subaddress after each complete set.
// - Only the last partial set is discarded; earlier sets are kept.
// - Write: address with direction 0, subaddress, data, then stop.
// - Read: subaddress write, repeated start, address with direction 1.
module i2cs_slave (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Two-wire bus pins
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // Core register port
  output logic [7:0]                  reg_addr,
  input  wire logic [`I2CS_CNT_W-1:0] reg_size,
  input  wire logic [7:0]             reg_bits,
  input  wire logic [`I2CS_BUF_W-1:0] rd_data,
  output logic                        wr_valid,
  output logic [7:0]                  wr_addr,
  output logic [`I2CS_BUF_W-1:0]      wr_data
);

  i2cs_pkg::i2cs_regs_type r;
  i2cs_pkg::i2cs_regs_type next_r;

  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_c;
  logic                   stop_c;
  logic [`I2CS_CNT_W-1:0] size_c;
  logic [7:0]             tx_c;

  // Byte count of one data set; high subaddresses round up to 4-byte groups
  function automatic logic [`I2CS_CNT_W-1:0] req_size(
    input logic [7:0]             sub,
    input logic [`I2CS_CNT_W-1:0] sz
  );
    logic [2:0] grp;
    grp = sz[4:2] + {2'b00, |sz[1:0]};
    if (sub >= `I2CS_MULTI_BASE) begin
      if (grp == 3'h0) begin
        grp = 3'h1;
      end
      req_size = {grp, 2'b00};
    end else begin
      req_size = (sz == 5'h00) ? 5'h01 : sz;
    end
  endfunction

  // Picks byte idx of a set, first byte most significant, zero above bits
  function automatic logic [7:0] tx_byte(
    input logic [`I2CS_BUF_W-1:0]  d,
    input logic [`I2CS_CNT_W-1:0]  sz,
    input logic [`I2CS_CNT_W-1:0]  idx,
    input logic [7:0]              bits
  );
    logic [8:0] pos;
    tx_byte = 8'h00;
    for (int k = 0; k < 8; k++) begin
      pos = {1'b0, 5'(sz - idx - 5'h01), 3'h0} + 9'(k);
      if (pos < {1'b0, bits} && pos < 9'(`I2CS_BUF_W)) begin
        tx_byte[k] = d[pos[7:0]];
      end
    end
  endfunction

  // Edge and condition detection against the previous pin sample
  assign scl_rise = scl_in & ~r.scl_q;
  assign scl_fall = ~scl_in & r.scl_q;
  assign start_c  = r.scl_q & scl_in & r.sda_q & ~sda_in;
  assign stop_c   = r.scl_q & scl_in & ~r.sda_q & sda_in;
  assign size_c   = req_size(r.sub_addr, reg_size);
  assign tx_c     = tx_byte(rd_data, size_c, r.cnt, reg_bits);

  // Protocol engine, moves only on the master's SCL edges and on start and stop conditions
  always_comb begin
    next_r          = r;
    next_r.scl_q    = scl_in;
    next_r.sda_q    = sda_in;
    next_r.wr_valid = 1'b0;
    next_r.sda_out  = 1'b0;
    if (start_c) begin
      next_r.st     = i2cs_pkg::ST_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe = 1'b0;
      next_r.cnt    = '0;
    end else if (stop_c) begin
      next_r.st     = i2cs_pkg::ST_IDLE;
      next_r.sda_oe = 1'b0;
      next_r.cnt    = '0;
    end else begin
      case (r.st)
        i2cs_pkg::ST_ADDR: begin
          if (scl_rise) begin
            next_r.shreg  = {r.shreg[6:0], sda_in};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == `I2CS_BYTE_BITS) begin
            if (r.shreg[7:1] == `I2CS_DEV_ADDR) begin
              next_r.rw     = r.shreg[0];
              next_r.sda_oe = 1'b1;
              next_r.st     = i2cs_pkg::ST_ACK;
              next_r.cnt    = '0;
              if (!r.shreg[0]) begin
                next_r.sub_phase = 1'b1;
              end
            end else begin
              next_r.st = i2cs_pkg::ST_IGNORE;
            end
          end
        end
        i2cs_pkg::ST_ACK: begin
          if (scl_fall) begin
            next_r.bitcnt = 4'h0;
            if (r.rw) begin
              next_r.st     = i2cs_pkg::ST_TX;
              next_r.shreg  = tx_c;
              next_r.sda_oe = ~tx_c[7];
              next_r.bitcnt = 4'h1;
            end else begin
              next_r.st     = i2cs_pkg::ST_RX;
              next_r.sda_oe = 1'b0;
            end
          end
        end
        i2cs_pkg::ST_RX: begin
          if (scl_rise) begin
            next_r.shreg  = {r.shreg[6:0], sda_in};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == `I2CS_BYTE_BITS) begin
            next_r.sda_oe = 1'b1;
            next_r.st     = i2cs_pkg::ST_ACK;
            if (r.sub_phase) begin
              next_r.sub_addr  = r.shreg;
              next_r.sub_phase = 1'b0;
              next_r.cnt       = '0;
            end else begin
              if (r.cnt == '0) begin
                next_r.dbuf = {{(`I2CS_BUF_W-8){1'b0}}, r.shreg}; // New set starts clean
              end else begin
                next_r.dbuf = {r.dbuf[`I2CS_BUF_W-9:0], r.shreg};
              end
              if (r.cnt + 5'h01 >= size_c) begin
                next_r.wr_valid = 1'b1;
                next_r.wr_addr  = r.sub_addr;
                next_r.sub_addr = r.sub_addr + 8'h01;
                next_r.cnt      = '0;
              end else begin
                next_r.cnt = r.cnt + 5'h01;
              end
            end
          end
        end
        i2cs_pkg::ST_TX: begin
          if (scl_fall) begin
            if (r.bitcnt == `I2CS_BYTE_BITS) begin
              next_r.sda_oe = 1'b0;
              next_r.st     = i2cs_pkg::ST_TXACK;
            end else begin
              next_r.sda_oe = ~r.shreg[6];
              next_r.shreg  = {r.shreg[6:0], 1'b0};
              next_r.bitcnt = r.bitcnt + 4'h1;
            end
          end
        end
        i2cs_pkg::ST_TXACK: begin
          if (scl_rise) begin
            if (sda_in) begin
              next_r.st = i2cs_pkg::ST_IGNORE;
            end else begin
              next_r.st = i2cs_pkg::ST_ACK;
              if (r.cnt + 5'h01 >= size_c) begin
                next_r.sub_addr = r.sub_addr + 8'h01;
                next_r.cnt      = '0;
              end else begin
                next_r.cnt = r.cnt + 5'h01;
              end
            end
          end
        end
        default: begin
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; pins idle high so no false condition after reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r          <= '0;
      r.st       <= i2cs_pkg::ST_IDLE;
      r.scl_q    <= 1'b1;
      r.sda_q    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign sda_out  = r.sda_out;
  assign sda_oe   = r.sda_oe;
  assign reg_addr = r.sub_addr;
  assign wr_valid = r.wr_valid;
  assign wr_addr  = r.wr_addr;
  assign wr_data  = r.dbuf;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Pin is only ever pulled low, and only in acknowledge or data slots
  drive_low_only_a: assert property (
    sda_out == 1'b0 && (!sda_oe || r.st == i2cs_pkg::ST_ACK || r.st == i2cs_pkg::ST_TX))
    else $error("sda driven out of slot");

  // Subaddress byte is latched and acknowledged, never committed
  sub_latch_a: assert property (
    (r.st == i2cs_pkg::ST_RX && scl_fall && !start_c && !stop_c &&
     r.bitcnt == `I2CS_BYTE_BITS && r.sub_phase)
    |=> (r.sub_addr == $past(r.shreg) && sda_oe && !wr_valid))
    else $error("subaddress byte not latched");

  // Every received data byte is acknowledged in the next bus period
  data_ack_a: assert property (
    (r.st == i2cs_pkg::ST_RX && scl_fall && !start_c && !stop_c &&
     r.bitcnt == `I2CS_BYTE_BITS && !r.sub_phase)
    |=> (sda_oe && r.st == i2cs_pkg::ST_ACK))
    else $error("data byte not acknowledged");

  // Read byte starts with its top bit on the pin after the acknowledge
  tx_load_a: assert property (
    (r.st == i2cs_pkg::ST_ACK && r.rw && scl_fall && !start_c && !stop_c)
    |=> (r.st == i2cs_pkg::ST_TX && sda_oe == !$past(tx_c[7])))
    else $error("read byte not loaded");

  // Matching address gets an acknowledge on the following cycle
  addr_ack_a: assert property (
    (r.st == i2cs_pkg::ST_ADDR && scl_fall && !start_c && !stop_c &&
     r.bitcnt == 4'h8 && r.shreg[7:1] == 7'h1B)
    |=> (sda_oe && r.st == i2cs_pkg::ST_ACK))
    else $error("address match not acknowledged");

  // Foreign address leaves the pin released
  addr_ignore_a: assert property (
    (r.st == i2cs_pkg::ST_ADDR && scl_fall && !start_c && !stop_c &&
     r.bitcnt == 4'h8 && r.shreg[7:1] != 7'h1B)
    |=> (!sda_oe && r.st == i2cs_pkg::ST_IGNORE))
    else $error("foreign address not ignored");

  // Start moves to address phase with partial data dropped
  start_seen_a: assert property (
    start_c |=> (r.st == i2cs_pkg::ST_ADDR && r.cnt == 5'h00 &&
                 !sda_oe && !wr_valid))
    else $error("start not handled");

  // Stop returns to idle with the pin released
  stop_seen_a: assert property (
    stop_c |=> (r.st == i2cs_pkg::ST_IDLE && !sda_oe && r.cnt == 5'h00))
    else $error("stop not handled");

  // Drive changes only while SCL is low
  drive_scl_low_a: assert property (
    ($changed(sda_oe) && !$past(start_c) && !$past(stop_c)) |-> !r.scl_q)
    else $error("sda changed with scl high");

  // Commit advances the subaddress by one and restarts the count
  commit_step_a: assert property (
    wr_valid |-> (r.cnt == 5'h00 && r.sub_addr == wr_addr + 8'h01 &&
                  $past(r.st) == i2cs_pkg::ST_RX))
    else $error("commit without subaddress step");

  // Not-acknowledge ends sending and releases the pin
  read_nack_a: assert property (
    (r.st == i2cs_pkg::ST_TXACK && scl_rise && sda_in && !start_c && !stop_c)
    |=> (r.st == i2cs_pkg::ST_IGNORE && !sda_oe) ##1 !sda_oe)
    else $error("read not ended on nack");

endmodule

/* i2cs_master_model.sv */
// Purpose: Bus master model for the two-wire control slave
// Assumes: The testbench calls its tasks one at a time
// Notes:   Only pulls SDA low or releases it; SCL high for 5 cycles
`timescale 1ns/1ps

module i2cs_master_model (
  // Clock
  input  wire logic sys_clk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_m
);
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Waits n clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One bit: SDA set while SCL low, sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    tick(3);
    scl <= 1'b1;
    tick(5);
    r = sda_line;
    scl <= 1'b0;
    tick(2);
  endtask

  // Start, also serves as repeated start
  task automatic start;
    sda_m <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(5);
    sda_m <= 1'b0;
    tick(5);
    scl <= 1'b0;
    tick(2);
  endtask

  // Stop ends the transfer
  task automatic stop;
    sda_m <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(5);
    sda_m <= 1'b1;
    tick(5);
  endtask

  // Sends a byte, returns the acknowledge level
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, ack);
  endtask

  // Reads a byte, then answers with ack or nack
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(nack, r);
  endtask
endmodule

/* test_i2c_control_slave.sv */
// Purpose: Self-checking bench of the two-wire control slave
// Assumes: Core answers size, bits and data from a small table
// Notes:   Low subaddresses are 1 byte of 6 bits, high ones 4 bytes
`timescale 1ns/1ps
`include "i2cs_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

module test_i2c_control_slave;
  logic                     sys_clk;
  logic                     rst_b;
  logic                     scl;
  logic                     sda_m;
  logic                     sda_out;
  logic                     sda_oe;
  logic [7:0]               reg_addr;
  logic [`I2CS_CNT_W-1:0]   reg_size;
  logic [7:0]               reg_bits;
  logic [`I2CS_BUF_W-1:0]   rd_data;
  logic                     wr_valid;
  logic [7:0]               wr_addr;
  logic [`I2CS_BUF_W-1:0]   wr_data;
  int                       n_fail;
  int                       checks;
  logic [7:0]               got_a[$];
  logic [`I2CS_BUF_W-1:0]   got_d[$];
  logic                     ack;
  logic [7:0]               rd;
  wire                      sda_line = sda_m & ~sda_oe;

  i2cs_slave dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_size(reg_size),
    .reg_bits(reg_bits), .rd_data(rd_data), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data));
  i2cs_master_model m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

  // Core lookup table
  always_comb begin
    reg_size = (reg_addr < 8'h20) ? 5'h01 : 5'h04;
    reg_bits = (reg_addr < 8'h20) ? 8'h06 : 8'h20;
    rd_data = {152'h0, reg_addr ^ 8'hA5};
  end

  // Records committed sets
  always @(posedge sys_clk) begin
    if (wr_valid === 1'b1) begin
      got_a.push_back(wr_addr);
      got_d.push_back(wr_data);
    end
  end

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic finish_test;
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Writes a byte and checks the answer
  task automatic wb(input logic [7:0] d, input logic e);
    m.wr_byte(d, ack);
    `CHK(ack, e)
    `CHK(sda_out, 1'b0)
  endtask

  // Foreign address is never answered
  task automatic t_foreign;
    m.start();
    wb(8'h34, 1'b1);
    wb(8'h05, 1'b1);
    m.stop();
    `CHK(got_a.size(), 0)
  endtask

  // Single byte write
  task automatic t_single;
    m.start();
    wb(8'h36, 1'b0);
    wb(8'h05, 1'b0);
    wb(8'h5A, 1'b0);
    m.stop();
    `CHK(got_a.size(), 1)
    `CHK(got_a[0], 8'h05)
    `CHK(got_d[0], {152'h0, 8'h5A})
    `CHK(reg_addr, 8'h06)
  endtask

  // Sequential write of two whole groups and a partial one
  task automatic t_seq;
    logic [7:0] b[10] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99, 8'hAA};
    got_a.delete();
    got_d.delete();
    m.start();
    wb(8'h36, 1'b0);
    wb(8'h20, 1'b0);
    for (int i = 0; i < 10; i++) begin
      wb(b[i], 1'b0);
    end
    m.stop();
    `CHK(got_a.size(), 2)
    `CHK(got_a[0], 8'h20)
    `CHK(got_d[0], {128'h0, 32'h1122_3344})
    `CHK(got_a[1], 8'h21)
    `CHK(got_d[1], {128'h0, 32'h5566_7788})
    `CHK(reg_addr, 8'h22)
  endtask

  // Read through repeated start, two bytes
  task automatic t_read;
    got_a.delete();
    m.start();
    wb(8'h36, 1'b0);
    wb(8'h06, 1'b0);
    m.start();
    wb(8'h37, 1'b0);
    m.rd_byte(1'b0, rd);
    `CHK(rd, 8'h23)
    m.rd_byte(1'b1, rd);
    `CHK(rd, 8'h22)
    `CHK(sda_oe, 1'b0)
    m.stop();
    `CHK(got_a.size(), 0)
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk);
    `CHK(sda_oe, 1'b0)
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_foreign();
    t_single();
    t_seq();
    t_read();
    finish_test();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    finish_test();
  end
endmodule
